// File: bench/pin_partner.sv
`timescale 1ns/1ps
module pin_partner
    import timer_pkg::*;
#(parameter int DLY = 2)
(
    input wire logic [NUM_CH-1:0] level,
    input wire logic [NUM_CH-1:0] ch_pin_o,
    input wire logic [NUM_CH-1:0] ch_pin_oe_n,
    output logic [NUM_CH-1:0] ch_pin_i
);
    // no pull on the line: a released pin shows the source level
    assign #(DLY) ch_pin_i = (ch_pin_oe_n & level) |
                             (~ch_pin_oe_n & ch_pin_o);
endmodule

// File: bench/timer_channels_sva.sv
`timescale 1ns/1ps
module timer_channels_sva
    import timer_pkg::*;
(
    input wire logic clock,
    input wire logic resetn,
    input wire bus_req_t bus_req,
    input wire logic [7:0] rd_data,
    input wire logic [NUM_CH-1:0] ch_pin_i,
    input wire logic [NUM_CH-1:0] ch_pin_o,
    input wire logic [NUM_CH-1:0] ch_pin_oe_n,
    input wire logic overflow_irq,
    input wire logic [NUM_CH-1:0] channel_irq
);
    // ==========================================================
    // decoded writes
    wire main_wr = bus_req.wr && bus_req.addr == ADDR_MAIN_CTRL;
    wire ch0_wr = bus_req.wr && bus_req.addr == ADDR_CH_BASE;
    wire ch1_wr = bus_req.wr && bus_req.addr == ADDR_CH_BASE + CH_STRIDE;

    default clocking dc @(posedge clock);
    endclocking
    default disable iff (!resetn);

    // ==========================================================
    // properties
    irq_hold_a: assert property (
        overflow_irq && !main_wr |=> overflow_irq)
        else $error("overflow request dropped");
    off_clears_a: assert property (
        main_wr && !bus_req.wdata[6] |=> !overflow_irq)
        else $error("overflow request with enable off");
    ch0_clear_a: assert property (
        $fell(channel_irq[0]) |-> $past(ch0_wr))
        else $error("channel 0 flag lost");
    ch1_clear_a: assert property (
        $fell(channel_irq[1]) |-> $past(ch1_wr))
        else $error("channel 1 flag lost");
    oe_cause_a: assert property (
        $changed(ch_pin_oe_n) |-> $past(bus_req.wr))
        else $error("pin enable moved without a write");
    pin_rst_a: assert property (
        $rose(resetn) |-> ch_pin_o == '0 && ch_pin_oe_n == '1)
        else $error("pins not idle after reset");
    irq_rst_a: assert property (
        $rose(resetn) |-> !overflow_irq && channel_irq == '0)
        else $error("requests active after reset");
    rd_idle_a: assert property (
        !bus_req.rd |=> rd_data == 8'h00)
        else $error("read data without a read");
    // stopped counter means no matches or overflows, so pins must hold
    pin_frozen_a: assert property (
        main_wr && !bus_req.wdata[3] ##1 (!bus_req.wr) [*4]
        |=> $stable(ch_pin_o))
        else $error("pin moved while counter stopped");
endmodule

bind timer_channels timer_channels_sva sva_u (.clock(clock),
    .resetn(resetn), .bus_req(bus_req), .rd_data(rd_data),
    .ch_pin_i(ch_pin_i), .ch_pin_o(ch_pin_o), .ch_pin_oe_n(ch_pin_oe_n),
    .overflow_irq(overflow_irq), .channel_irq(channel_irq));

// File: bench/timer_channels_tb_top.sv
`timescale 1ns/1ps
module timer_channels_tb_top;
    import timer_pkg::*;
    localparam logic [7:0] CH0 = ADDR_CH_BASE;
    localparam logic [7:0] CH1 = ADDR_CH_BASE + CH_STRIDE;
    logic clock;
    logic resetn;
    bus_req_t req;
    logic [7:0] rd_data, d, hi, lo;
    logic [NUM_CH-1:0] pin_i, pin_o, pin_oe_n, ch_irq, lvl;
    logic ov_irq;
    int bad_count = 0;
    int num_checks = 0;
    int cyc = 0;
    int m, v, t1, t2, n, h, c;
    int vals[3];
    int acts[4] = '{1, 2, 3, 0};
    integer seed = 32'hFAB26E74;

    timer_channels dut_u (.clock(clock), .resetn(resetn), .bus_req(req),
        .rd_data(rd_data), .ch_pin_i(pin_i), .ch_pin_o(pin_o),
        .ch_pin_oe_n(pin_oe_n), .overflow_irq(ov_irq), .channel_irq(ch_irq));
    pin_partner #(.DLY(2)) far_u (.level(lvl), .ch_pin_o(pin_o),
        .ch_pin_oe_n(pin_oe_n), .ch_pin_i(pin_i));

    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    always @(posedge clock) cyc <= cyc + 1;

    // ==========================================================
    // helpers
    task automatic tick();
        @(posedge clock);
        #1;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("unexpected at %0t: saw %0h not %0h", $time, seen, exp);
        end
    endtask
    // one idle cycle after each strobe keeps req single-assigned per step
    task automatic wr(input logic [7:0] a, input logic [7:0] x);
        @(posedge clock);
        req <= '{a, x, 1'b1, 1'b0};
        @(posedge clock);
        req <= '{a, x, 1'b0, 1'b0};
        #1;
    endtask
    // read data stands only in the cycle after the strobe edge
    task automatic rd(input logic [7:0] a, output logic [7:0] x);
        @(posedge clock);
        req <= '{a, 8'h00, 1'b0, 1'b1};
        @(posedge clock);
        req <= '{a, 8'h00, 1'b0, 1'b0};
        #1;
        x = rd_data;
    endtask
    task automatic wait_ov(output int t);
        n = 0;
        while (ov_irq !== 1'b1 && n < 200) begin
            tick();
            n++;
        end
        chk(ov_irq, 1'b1);
        t = cyc;
    endtask
    task automatic clr_ov(input logic [7:0] mc);
        rd(ADDR_MAIN_CTRL, d);
        chk(d[7], 1'b1);
        wr(ADDR_MAIN_CTRL, mc);
        chk(ov_irq, 1'b0);
    endtask
    task automatic watch(input int ch, input int len);
        logic p;
        h = 0;
        c = 0;
        p = pin_o[ch];
        repeat (len) begin
            tick();
            if (pin_o[ch] === 1'b1) h++;
            if (pin_o[ch] !== p) c++;
            p = pin_o[ch];
        end
    endtask
    function automatic logic [31:0] duty(input int val, input logic pol);
        int k;
        k = (val > m) ? 2 * (m + 1) : 2 * val;
        return pol ? 2 * (m + 1) - k : k;
    endfunction
    task automatic final_report();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // ==========================================================
    // sequence
    initial begin
        req = '0;
        resetn = 1'b0;
        lvl = '0;
        repeat (3) @(posedge clock);
        resetn <= 1'b1;
        tick();
        m = 6 + $unsigned($random(seed)) % 16;
        v = 1 + $unsigned($random(seed)) % (m - 1);
        wr(ADDR_MOD_HI, 8'h00);
        wr(ADDR_MOD_LO, 8'(m));
        wr(ADDR_MAIN_CTRL, 8'h48);
        wait_ov(t1);
        clr_ov(8'h48);
        wait_ov(t2);
        chk(t2 - t1, m + 1);
        $display("done overflow up");
        // half value must be dropped by the control write
        wr(CH1, 8'h50);
        wr(CH1 + 8'h01, 8'h00);
        wr(CH1 + 8'h02, 8'(v));
        wr(CH1 + 8'h01, 8'hFF);
        wr(CH1, 8'h54);
        wr(CH1 + 8'h02, 8'(v));
        foreach (acts[i]) begin
            rd(CH1, d);
            wr(CH1, 8'h50 | 8'(acts[i] << 2));
            watch(1, 2 * (m + 1));
            chk(ch_irq[1], 1'b1);
            case (acts[i])
                1: chk(c, 2);
                2: chk(pin_o[1], 1'b0);
                3: chk(pin_o[1], 1'b1);
                default: chk({c[30:0], pin_oe_n[1]}, 1);
            endcase
        end
        $display("done compare");
        vals = '{0, v, m + 1};
        for (int pol = 0; pol < 2; pol++) begin
            foreach (vals[j]) begin
                wr(CH0, 8'h28 | 8'(pol << 2));
                wr(CH0 + 8'h01, 8'h00);
                wr(CH0 + 8'h02, 8'(vals[j]));
                repeat (2 * (m + 1)) tick();
                watch(0, 2 * (m + 1));
                chk(h, duty(vals[j], pol[0]));
                chk(pin_oe_n[0], 1'b0);
            end
        end
        $display("done edge pwm");
        wr(ADDR_MAIN_CTRL, 8'h00);
        rd(ADDR_CNT_HI, hi);
        rd(ADDR_CNT_LO, lo);
        wr(CH0, 8'h40);
        repeat (8) tick();
        for (int e = 1; e < 4; e++) begin
            rd(CH0, d);
            wr(CH0, 8'h40 | 8'(e << 2));
            lvl[0] <= 1'b1;
            repeat (8) tick();
            chk(ch_irq[0], e != 2);
            rd(CH0, d);
            wr(CH0, 8'h40 | 8'(e << 2));
            lvl[0] <= 1'b0;
            repeat (8) tick();
            chk(ch_irq[0], e != 1);
        end
        rd(CH0 + 8'h01, d);
        chk(d, hi);
        rd(CH0 + 8'h02, d);
        chk(d, lo);
        $display("done capture");
        wr(ADDR_CNT_LO, 8'h00);
        clr_ov(8'h68);
        wait_ov(t1);
        clr_ov(8'h68);
        wait_ov(t2);
        chk(t2 - t1, 2 * m);
        watch(1, 2 * m);
        chk(h, duty(v, 1'b0));
        wr(CH1 + 8'h01, 8'h80);
        wr(CH1 + 8'h02, 8'h00);
        repeat (4 * m) tick();
        watch(1, 2 * m);
        chk(h, 0);
        wr(CH1 + 8'h02, 8'(m + 1));
        wr(CH1 + 8'h01, 8'h00);
        repeat (4 * m) tick();
        watch(1, 2 * m);
        chk(h, 2 * m);
        $display("done center");
        final_report();
    end

    initial begin
        repeat (20000) @(posedge clock);
        bad_count++;
        final_report();
    end
endmodule

// File: common/timer_pkg.sv
package timer_pkg;

    // ==========================================================
    // register map
    localparam int NUM_CH = 2;
    localparam logic [7:0] ADDR_MAIN_CTRL = 8'h00;
    localparam logic [7:0] ADDR_CNT_HI = 8'h01;
    localparam logic [7:0] ADDR_CNT_LO = 8'h02;
    localparam logic [7:0] ADDR_MOD_HI = 8'h03;
    localparam logic [7:0] ADDR_MOD_LO = 8'h04;
    localparam logic [7:0] ADDR_CH_BASE = 8'h05;
    localparam logic [7:0] CH_STRIDE = 8'h03;
    localparam logic [7:0] CH_CTRL_OFS = 8'h00;
    localparam logic [7:0] CH_VAL_HI_OFS = 8'h01;
    localparam logic [7:0] CH_VAL_LO_OFS = 8'h02;
    localparam int FLAG_BIT = 7;

    // ==========================================================
    // reset values and counts
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [15:0] CNT_ZERO = 16'h0000;
    localparam logic [15:0] CNT_MAX = 16'hFFFF;
    localparam logic [15:0] CNT_ONE = 16'h0001;

    // ==========================================================
    // types
    typedef struct packed {
        logic overflow_flag;
        logic overflow_irq_enable;
        logic center_align_select;
        logic rsvd4;
        logic count_enable;
        logic [2:0] rsvd;
    } main_ctrl_t;

    typedef struct packed {
        logic channel_event_flag;
        logic channel_irq_enable;
        logic mode_select_high;
        logic mode_select_low;
        logic edge_level_select_high;
        logic edge_level_select_low;
        logic [1:0] rsvd;
    } chan_ctrl_t;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } bus_req_t;

    typedef enum logic [1:0] {
        CH_CAPTURE = 2'b00,
        CH_COMPARE = 2'b01,
        CH_EDGE_PWM = 2'b10,
        CH_CENTER_PWM = 2'b11
    } ch_mode_t;

    typedef enum logic {
        DIR_UP = 1'b0,
        DIR_DOWN = 1'b1
    } dir_t;

endpackage

// File: core/timer_channels.sv
// Local design decisions: the plain strobed port and the address map.
`timescale 1ns/1ps
module timer_channels
    import timer_pkg::*;
(
    input wire logic clock,
    input wire logic resetn,
    input wire bus_req_t bus_req,
    output logic [7:0] rd_data,
    input wire logic [NUM_CH-1:0] ch_pin_i,
    output logic [NUM_CH-1:0] ch_pin_o,
    output logic [NUM_CH-1:0] ch_pin_oe_n,
    output logic overflow_irq,
    output logic [NUM_CH-1:0] channel_irq
);

    // ==========================================================
    // decode
    function automatic logic [7:0] ch_addr(input int ch,
                                           input logic [7:0] ofs);
        return ADDR_CH_BASE + CH_STRIDE * ch[7:0] + ofs;
    endfunction

    wire wr_main = bus_req.wr && bus_req.addr == ADDR_MAIN_CTRL;
    wire rd_main = bus_req.rd && bus_req.addr == ADDR_MAIN_CTRL;
    wire wr_cnt = bus_req.wr && (bus_req.addr == ADDR_CNT_HI ||
                                 bus_req.addr == ADDR_CNT_LO);
    wire wr_mod_hi = bus_req.wr && bus_req.addr == ADDR_MOD_HI;
    wire wr_mod_lo = bus_req.wr && bus_req.addr == ADDR_MOD_LO;

    main_ctrl_t main_q;
    main_ctrl_t main_d;
    logic [15:0] cnt_q;
    logic [15:0] cnt_d;
    dir_t dir_q;
    dir_t dir_d;
    logic [15:0] mod_q;
    logic [15:0] mod_buf_q;
    logic mod_hi_q;
    logic mod_lo_q;
    logic ovf_arm_q;
    logic [7:0] rd_data_q;

    wire center = main_q.center_align_select;
    wire run = main_q.count_enable;
    wire [15:0] term = (mod_q == CNT_ZERO) ? CNT_MAX : mod_q;

    // ==========================================================
    // counter
    // up/down turn at modulus, or wrap at terminal count
    wire ovf_evt = run && (center ? (dir_q == DIR_UP && cnt_q == mod_q)
                                  : cnt_q == term);
    // a stopped counter sitting at zero also counts as zero
    wire edge_load = (ovf_evt && !center) ||
                     (!run && cnt_q == CNT_ZERO);

    always_comb begin
        cnt_d = cnt_q;
        dir_d = center ? dir_q : DIR_UP;
        if (wr_cnt) begin
            cnt_d = CNT_ZERO;
            dir_d = DIR_UP;
        end else if (run && center) begin
            // every count, zero and modulus too, lasts one clock
            if (dir_q == DIR_UP && cnt_q == mod_q) begin
                dir_d = DIR_DOWN;
                cnt_d = cnt_q - CNT_ONE;
            end else if (dir_q == DIR_DOWN && cnt_q == CNT_ZERO) begin
                dir_d = DIR_UP;
                cnt_d = cnt_q + CNT_ONE;
            end else if (dir_q == DIR_UP) begin
                cnt_d = cnt_q + CNT_ONE;
            end else begin
                cnt_d = cnt_q - CNT_ONE;
            end
        end else if (run) begin
            cnt_d = (cnt_q == term) ? CNT_ZERO : cnt_q + CNT_ONE;
        end
    end

    // ==========================================================
    // main control and overflow flag
    wire ovf_clr = wr_main && !bus_req.wdata[FLAG_BIT] && ovf_arm_q;

    always_comb begin
        main_d = main_q;
        if (wr_main) begin
            main_d = main_ctrl_t'(bus_req.wdata);
            main_d.rsvd4 = 1'b0;
            main_d.rsvd = 3'h0;
        end
        // set wins over a clear in the same cycle
        main_d.overflow_flag = ovf_evt ||
                               (main_q.overflow_flag && !ovf_clr);
    end

    // modulus pairs load at once in edge-aligned mode, else at the turn
    wire mod_load = mod_hi_q && mod_lo_q && (!center || ovf_evt);

    always_ff @(posedge clock) begin
        if (!resetn) begin
            main_q <= main_ctrl_t'(CTRL_RESET);
            cnt_q <= CNT_ZERO;
            dir_q <= DIR_UP;
            ovf_arm_q <= 1'b0;
        end else begin
            main_q <= main_d;
            cnt_q <= cnt_d;
            dir_q <= dir_d;
            if (ovf_evt || wr_main) begin
                ovf_arm_q <= 1'b0;
            end else if (rd_main && main_q.overflow_flag) begin
                ovf_arm_q <= 1'b1;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (!resetn) begin
            mod_q <= CNT_ZERO;
            mod_buf_q <= CNT_ZERO;
            mod_hi_q <= 1'b0;
            mod_lo_q <= 1'b0;
        end else begin
            if (wr_mod_hi) begin
                mod_buf_q[15:8] <= bus_req.wdata;
            end
            if (wr_mod_lo) begin
                mod_buf_q[7:0] <= bus_req.wdata;
            end
            if (mod_load) begin
                mod_q <= mod_buf_q;
            end
            if (wr_main || mod_load) begin
                mod_hi_q <= 1'b0;
                mod_lo_q <= 1'b0;
            end else begin
                mod_hi_q <= mod_hi_q || wr_mod_hi;
                mod_lo_q <= mod_lo_q || wr_mod_lo;
            end
        end
    end

    assign overflow_irq = main_q.overflow_flag &&
                          main_q.overflow_irq_enable;

    // ==========================================================
    // channels
    logic [7:0] ch_rd [NUM_CH];

    for (genvar g = 0; g < NUM_CH; g++) begin : g_ch
        chan_ctrl_t cc_q;
        logic [15:0] val_q;
        logic [15:0] vbuf_q;
        logic [15:0] snap_q;
        logic vhi_q;
        logic vlo_q;
        logic lock_q;
        logic lock_hi_q;
        logic arm_q;
        logic sync1_q;
        logic sync2_q;
        logic prev_q;
        logic out_q;
        logic out_d;

        wire is_cc = bus_req.addr == ch_addr(g, CH_CTRL_OFS);
        wire is_hi = bus_req.addr == ch_addr(g, CH_VAL_HI_OFS);
        wire is_lo = bus_req.addr == ch_addr(g, CH_VAL_LO_OFS);
        wire wr_cc = bus_req.wr && is_cc;
        wire rd_cc = bus_req.rd && is_cc;
        wire wr_hi = bus_req.wr && is_hi;
        wire wr_lo = bus_req.wr && is_lo;
        wire rd_val = bus_req.rd && (is_hi || is_lo);

        wire [1:0] els = {cc_q.edge_level_select_high,
                          cc_q.edge_level_select_low};
        wire pol = cc_q.edge_level_select_low;
        // center bit overrides every channel's own mode
        wire ch_mode_t mode = center ? CH_CENTER_PWM :
            cc_q.mode_select_high ? CH_EDGE_PWM :
            cc_q.mode_select_low ? CH_COMPARE : CH_CAPTURE;

        // only the second sync stage feeds the edge detector
        wire rise = sync2_q && !prev_q;
        wire fall = !sync2_q && prev_q;
        wire cap_evt = mode == CH_CAPTURE &&
            ((els[0] && rise) || (els[1] && fall));
        wire match = run && mode != CH_CAPTURE &&
                     cnt_q == val_q;
        wire evt = cap_evt || match;

        wire both = vhi_q && vlo_q;
        wire load = both && (mode == CH_CAPTURE ||
            mode == CH_COMPARE ||
            (mode == CH_EDGE_PWM && edge_load) ||
            (mode == CH_CENTER_PWM && ovf_evt));
        wire [15:0] val_eff = load ? vbuf_q : val_q;
        wire cpwm_off = val_q == CNT_ZERO || val_q[15];

        wire flag_clr = wr_cc && !bus_req.wdata[FLAG_BIT] && arm_q;
        wire flag_nx = evt ||
            (cc_q.channel_event_flag && !flag_clr);
        wire [15:0] vrd = lock_q ? snap_q : val_q;

        assign ch_rd[g] = is_cc ? cc_q :
                          is_hi ? vrd[15:8] :
                          is_lo ? vrd[7:0] : 8'h00;

        // edge pwm looks at the next count so the duty is exact
        always_comb begin
            out_d = out_q;
            case (mode)
                CH_COMPARE: begin
                    if (match) begin
                        case (els)
                            2'b01: out_d = !out_q;
                            2'b10: out_d = 1'b0;
                            2'b11: out_d = 1'b1;
                            default: out_d = out_q;
                        endcase
                    end
                end
                CH_EDGE_PWM: begin
                    // match wins over wrap, so zero value gives 0%
                    if (run && cnt_d == val_eff) begin
                        out_d = pol;
                    end else if (ovf_evt) begin
                        out_d = !pol;
                    end
                end
                CH_CENTER_PWM: begin
                    if (cpwm_off) begin
                        out_d = pol;
                    end else if (val_q > mod_q) begin
                        out_d = !pol;
                    end else if (match) begin
                        out_d = (dir_q == DIR_UP) ? pol : !pol;
                    end
                end
                default: out_d = out_q;
            endcase
        end

        always_ff @(posedge clock) begin
            if (!resetn) begin
                sync1_q <= 1'b0;
                sync2_q <= 1'b0;
                prev_q <= 1'b0;
                out_q <= 1'b0;
            end else begin
                sync1_q <= ch_pin_i[g];
                sync2_q <= sync1_q;
                prev_q <= sync2_q;
                out_q <= out_d;
            end
        end

        always_ff @(posedge clock) begin
            if (!resetn) begin
                cc_q <= chan_ctrl_t'(CTRL_RESET);
                arm_q <= 1'b0;
            end else begin
                if (wr_cc) begin
                    cc_q <= chan_ctrl_t'(bus_req.wdata);
                    cc_q.rsvd <= 2'h0;
                end
                cc_q.channel_event_flag <= flag_nx;
                if (evt || wr_cc) begin
                    arm_q <= 1'b0;
                end else if (rd_cc && cc_q.channel_event_flag) begin
                    arm_q <= 1'b1;
                end
            end
        end

        always_ff @(posedge clock) begin
            if (!resetn) begin
                val_q <= CNT_ZERO;
                vbuf_q <= CNT_ZERO;
                vhi_q <= 1'b0;
                vlo_q <= 1'b0;
            end else begin
                if (cap_evt) begin
                    val_q <= cnt_q;
                end else if (load) begin
                    val_q <= vbuf_q;
                end
                if (wr_hi) begin
                    vbuf_q[15:8] <= bus_req.wdata;
                end
                if (wr_lo) begin
                    vbuf_q[7:0] <= bus_req.wdata;
                end
                if (wr_cc || load) begin
                    vhi_q <= 1'b0;
                    vlo_q <= 1'b0;
                end else begin
                    vhi_q <= vhi_q || wr_hi;
                    vlo_q <= vlo_q || wr_lo;
                end
            end
        end

        // read freeze only matters while captures can land
        always_ff @(posedge clock) begin
            if (!resetn) begin
                snap_q <= CNT_ZERO;
                lock_q <= 1'b0;
                lock_hi_q <= 1'b0;
            end else if (wr_cc) begin
                lock_q <= 1'b0;
            end else if (rd_val && mode == CH_CAPTURE) begin
                if (!lock_q) begin
                    snap_q <= val_q;
                    lock_q <= 1'b1;
                    lock_hi_q <= is_hi;
                end else if (is_hi != lock_hi_q) begin
                    lock_q <= 1'b0;
                end
            end
        end

        assign ch_pin_o[g] = out_q;
        assign ch_pin_oe_n[g] = mode == CH_CAPTURE || els == 2'b00;
        assign channel_irq[g] = cc_q.channel_event_flag &&
                                cc_q.channel_irq_enable;
    end

    // ==========================================================
    // read data
    logic [7:0] rd_mux;

    always_comb begin
        case (bus_req.addr)
            ADDR_MAIN_CTRL: rd_mux = main_q;
            ADDR_CNT_HI: rd_mux = cnt_q[15:8];
            ADDR_CNT_LO: rd_mux = cnt_q[7:0];
            ADDR_MOD_HI: rd_mux = mod_q[15:8];
            ADDR_MOD_LO: rd_mux = mod_q[7:0];
            default: rd_mux = 8'h00;
        endcase
        for (int i = 0; i < NUM_CH; i++) begin
            rd_mux = rd_mux | ch_rd[i];
        end
    end

    always_ff @(posedge clock) begin
        if (!resetn) begin
            rd_data_q <= 8'h00;
        end else begin
            rd_data_q <= bus_req.rd ? rd_mux : 8'h00;
        end
    end

    assign rd_data = rd_data_q;

endmodule
